// ===== host_serial_frame_interface_bench.sv
`timescale 1ns/1ps
`include "hsfi_defs.vh"
module host_serial_frame_interface_bench;
    localparam [27:0] DEVT = 28'h0123456; // arbitrary value
    reg aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ack_retry_exhausted = 1'b0, tx_in_valid = 1'b0;
    reg link_is_spi = 1'b0, tx_in_start = 1'b0, send_en = 1'b0;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_in_data = 8'h00, send_byte = 8'h00;
    reg [31:0] s_axi_wdata = 32'h00000000, seed = 32'h0000B267;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pass_valid, frm_valid;
    wire frm_is_type, frm_good, frm_bad, tx_in_ready, tx_out_valid, tx_out_ready, rx_valid, cmd_mode;
    wire apply_pulse, save_pulse;
    wire [1:0] s_axi_bresp, s_axi_rresp, active_mode;
    wire [7:0] pass_data, frm_data, tx_out_data, rx_data;
    wire [31:0] s_axi_rdata;
    reg [36:0] eq[$];
    reg [7:0] sq[$];
    integer err_count = 0, check_count = 0, n;
    hsfi_top #(.MS_CYCLES(10), .DEVICE_TYPE(DEVT)) dut (.*);
    hsfi_host host (.*);
    initial forever #10 aclk = ~aclk;
    function [31:0] xs;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            xs = seed;
        end
    endfunction
    task chk(input string nm, input [36:0] s, input [36:0] e);
        begin
            check_count = check_count + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("unexpected %0s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task take(input [36:0] s);
        chk("result", s, eq.size() > 0 ? eq.pop_front() : {37{1'b1}});
    endtask
    // each result on the outputs retires the oldest note
    always @(posedge aclk) begin
        if (pass_valid) take({29'h0, pass_data});
        if (frm_valid) take({3'h1, 25'h0, frm_is_type, frm_data});
        if (frm_good | frm_bad) take({3'h2, 32'h0, frm_bad, frm_good});
        if (s_axi_rvalid & s_axi_rready) take({3'h3, s_axi_rresp, s_axi_rdata});
        if (tx_out_valid & tx_out_ready) take({3'h4, 26'h0, tx_out_data});
    end
    task wreg(input [7:0] a, input [31:0] d, input [1:0] r);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            @(posedge aclk);
            while (!s_axi_awready) @(posedge aclk);
            s_axi_awvalid <= 1'b0;
            s_axi_wvalid <= 1'b0;
            while (!s_axi_bvalid) @(posedge aclk);
            chk("bresp", 37'(s_axi_bresp), 37'(r));
            s_axi_bready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task rreg(input [7:0] a, input [33:0] e);
        begin
            eq.push_back({3'h3, e});
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            @(posedge aclk);
            while (!s_axi_arready) @(posedge aclk);
            s_axi_arvalid <= 1'b0;
            while (!s_axi_rvalid) @(posedge aclk);
            s_axi_rready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task send;
        begin
            while (sq.size() > 0) begin
                send_en <= 1'b1;
                send_byte <= sq.pop_front();
                @(posedge aclk);
            end
            send_en <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
    task tx(input [7:0] b);
        begin
            tx_in_valid <= 1'b1;
            tx_in_data <= b;
            @(posedge aclk);
            while (!tx_in_ready) @(posedge aclk);
            tx_in_valid <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task cmd(input [7:0] c);
        begin
            wreg(`HSFI_REG_CMD, {24'h0, c}, 2'h0);
            repeat (2) @(posedge aclk);
        end
    endtask
    // silence, three escape chars, silence; in transparent mode they also pass
    task enter(input tp);
        begin
            repeat (60) @(posedge aclk);
            if (tp) eq = {eq, 37'h2B, 37'h2B, 37'h2B};
            sq = {8'h2B, 8'h2B, 8'h2B};
            send;
            repeat (60) @(posedge aclk);
            chk("cmd", 37'(cmd_mode), 37'h1);
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d errors %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // hang guard, well past the longest expected run
    initial begin
        repeat (80000) @(posedge aclk);
        err_count = err_count + 1;
        give_verdict;
    end
    // main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rreg(`HSFI_REG_MODE, 34'h0);
        rreg(`HSFI_REG_ESC, 34'h2B);
        rreg(`HSFI_REG_GUARD, 34'h3E8);
        rreg(`HSFI_REG_CTO, 34'h64);
        rreg(`HSFI_REG_DEVID, {6'h0, DEVT});
        rreg(8'h20, 34'h200000000);
        wreg(`HSFI_REG_DEVID, 32'h1, 2'h2);
        wreg(`HSFI_REG_GUARD, 32'h1, 2'h0);
        rreg(`HSFI_REG_GUARD, 34'h2);
        wreg(`HSFI_REG_CTO, 32'h1, 2'h0);
        rreg(`HSFI_REG_CTO, 34'h2);
        n = xs() % 5 + 1;
        repeat (n) begin
            ack_retry_exhausted <= 1'b1;
            @(posedge aclk);
            ack_retry_exhausted <= 1'b0;
            @(posedge aclk);
        end
        rreg(`HSFI_REG_ACKF, 34'(n));
        wreg(`HSFI_REG_ACKF, 32'h0, 2'h0);
        rreg(`HSFI_REG_ACKF, 34'h0);
        ack_retry_exhausted <= 1'b1;
        repeat (65540) @(posedge aclk);
        ack_retry_exhausted <= 1'b0;
        rreg(`HSFI_REG_ACKF, 34'hFFFF);
        repeat (4) begin
            n = xs();
            sq.push_back(n[7:0]);
            eq.push_back({29'h0, n[7:0]});
        end
        send;
        wreg(`HSFI_REG_MODE, 32'h1, 2'h0);
        chk("mode", 37'(active_mode), 37'h0);
        enter(1'b1);
        cmd(`HSFI_CMD_APPLY);
        chk("mode", 37'({cmd_mode, active_mode}), 37'h5);
        cmd(`HSFI_CMD_EXIT);
        chk("cmd", 37'(cmd_mode), 37'h0);
        // junk before a good frame, then a bad checksum
        sq = {8'h55, 8'h7E, 8'h00, 8'h02, 8'h23, 8'h11, 8'hCB, 8'h7E, 8'h00, 8'h01, 8'h40, 8'h00};
        eq = {eq, 37'h400000123, 37'h400000011, 37'h800000001, 37'h400000140, 37'h800000002};
        send;
        wreg(`HSFI_REG_MODE, 32'h2, 2'h0);
        enter(1'b0);
        cmd(`HSFI_CMD_SAVE);
        chk("mode", 37'(active_mode), 37'h1);
        cmd(`HSFI_CMD_APPLY);
        chk("mode", 37'(active_mode), 37'h2);
        repeat (1900) @(posedge aclk);
        chk("cmd", 37'(cmd_mode), 37'h1);
        repeat (200) @(posedge aclk);
        chk("cmd", 37'(cmd_mode), 37'h0);
        // escaped byte, then a raw delimiter restarts a frame
        sq = {8'h7E, 8'h00, 8'h02, 8'h23, 8'h7D, 8'h31, 8'hCB, 8'h7E, 8'h00, 8'h03, 8'h41};
        sq = {sq, 8'h7E, 8'h00, 8'h01, 8'h42, 8'hBD};
        eq = {eq, 37'h400000123, 37'h400000011, 37'h800000001, 37'h400000141, 37'h800000002};
        eq = {eq, 37'h400000142, 37'h800000001};
        send;
        // reserved byte escaped, plain byte untouched
        eq = {eq, 37'h100000007E, 37'h100000007D, 37'h1000000031, 37'h1000000041};
        tx_in_start <= 1'b1;
        tx(8'h7E);
        tx_in_start <= 1'b0;
        tx(8'h11);
        tx(8'h41);
        repeat (10) @(posedge aclk);
        give_verdict;
    end
endmodule
bind hsfi_top hsfi_chk chk (.*);

// ===== hsfi_assertions.sv
`timescale 1ns/1ps
module hsfi_chk (
    input wire aclk,
    input wire aresetn,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire pass_valid,
    input wire [7:0] pass_data,
    input wire frm_valid,
    input wire frm_good,
    input wire frm_bad,
    input wire cmd_mode,
    input wire [1:0] active_mode,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire tx_out_valid,
    input wire tx_out_ready,
    input wire [7:0] tx_out_data
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awready && s_axi_wready;
    endsequence
    sequence wr_done;
        !s_axi_awready && s_axi_bvalid;
    endsequence
    a_pass_echo: assert property (rx_valid && active_mode == 2'h0 && !cmd_mode
        |=> pass_valid && pass_data == $past(rx_data)) else $error("byte not passed");
    a_rx_only: assert property (!rx_valid |=> !pass_valid && !frm_valid && !frm_good && !frm_bad)
        else $error("output without byte");
    a_good_xor_bad: assert property (!(frm_good && frm_bad))
        else $error("good and bad together");
    a_wr_answer: assert property (wr_take |=> wr_done)
        else $error("write answer late");
    a_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rd_pair: assert property ($rose(s_axi_arready) |-> s_axi_rvalid)
        else $error("arready without rvalid");
    a_tx_held: assert property (tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_data))
        else $error("tx byte dropped");
endmodule

// ===== hsfi_defs.vh
`ifndef HSFI_DEFS_VH
`define HSFI_DEFS_VH

// register byte offsets
`define HSFI_REG_MODE 8'h00
`define HSFI_REG_ESC 8'h04
`define HSFI_REG_GUARD 8'h08
`define HSFI_REG_CTO 8'h0C
`define HSFI_REG_ACKF 8'h10
`define HSFI_REG_DEVID 8'h14
`define HSFI_REG_CMD 8'h18
`define HSFI_REG_STATUS 8'h1C

// reset values
`define HSFI_RST_MODE 2'h0
`define HSFI_RST_ESC 8'h2B
`define HSFI_RST_GUARD 12'h3E8
`define HSFI_RST_CTO 13'h0064

// programmable ranges
`define HSFI_GUARD_MIN 12'h002
`define HSFI_GUARD_MAX 12'hCE4
`define HSFI_CTO_MIN 13'h0002
`define HSFI_CTO_MAX 13'h1770

// framing modes
`define HSFI_MODE_TRANSP 2'h0
`define HSFI_MODE_FRAME 2'h1
`define HSFI_MODE_ESCAPED 2'h2

// command codes written to the command register
`define HSFI_CMD_EXIT 8'h01
`define HSFI_CMD_APPLY 8'h02
`define HSFI_CMD_SAVE 8'h03
`define HSFI_CMD_OTHER 8'h04

// frame bytes
`define HSFI_DELIM 8'h7E
`define HSFI_ESCB 8'h7D
`define HSFI_XON 8'h11
`define HSFI_XOFF 8'h13
`define HSFI_ESC_XOR 8'h20
`define HSFI_CSUM_OK 8'hFF

// status field positions
`define HSFI_ST_CMD 0
`define HSFI_ST_MODE_LO 1
`define HSFI_ST_INFRAME 3
`define HSFI_ST_TYPE_LO 8

// timing
`define HSFI_CLK_PERIOD_NS 20
`define HSFI_MS_NS 1000000
`define HSFI_CTO_UNIT_MS 7'd100
`define HSFI_ESC_COUNT 2'd3

`endif

// ===== hsfi_host.sv
`timescale 1ns/1ps
module hsfi_host (
    input wire aclk,
    input wire send_en,
    input wire [7:0] send_byte,
    output reg rx_valid,
    output reg [7:0] rx_data,
    output reg tx_out_ready
);
    reg [1:0] beat = 2'h0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_out_ready = 1'b0;
    end
    // bytes leave as queued, one per clock; idle data toggles so it never looks fresh
    always @(posedge aclk) begin
        rx_valid <= send_en;
        rx_data <= send_en ? send_byte : ~rx_data;
        beat <= beat + 2'h1;
        tx_out_ready <= beat != 2'h0; // every frame type taken alike
    end
endmodule

// ===== hsfi_top.v
`timescale 1ns/1ps
`include "hsfi_defs.vh"

module hsfi_top #(
    parameter MS_CYCLES = `HSFI_MS_NS / `HSFI_CLK_PERIOD_NS,
    parameter [27:0] DEVICE_TYPE = 28'h0A5C3E1 // arbitrary value
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire link_is_spi,
    input wire ack_retry_exhausted,
    input wire rx_valid,
    input wire [7:0] rx_data,
    output reg pass_valid,
    output reg [7:0] pass_data,
    output reg frm_valid,
    output reg [7:0] frm_data,
    output reg frm_is_type,
    output reg frm_good,
    output reg frm_bad,
    input wire tx_in_valid,
    input wire [7:0] tx_in_data,
    input wire tx_in_start,
    output reg tx_in_ready,
    output reg tx_out_valid,
    output reg [7:0] tx_out_data,
    input wire tx_out_ready,
    output reg cmd_mode,
    output reg [1:0] active_mode,
    output reg apply_pulse,
    output reg save_pulse
);

    localparam [4:0] RX_START = 5'b00001;
    localparam [4:0] RX_LENHI = 5'b00010;
    localparam [4:0] RX_LENLO = 5'b00100;
    localparam [4:0] RX_DATA = 5'b01000;
    localparam [4:0] RX_CSUM = 5'b10000;
    localparam [2:0] SQ_IDLE = 3'b001;
    localparam [2:0] SQ_CHARS = 3'b010;
    localparam [2:0] SQ_POST = 3'b100;

    reg [1:0] framing_mode_select;
    reg [7:0] escape_sequence_char;
    reg [11:0] guard_silence_time;
    reg [12:0] cmd_mode_timeout;
    reg [15:0] ack_fail_count;
    reg [15:0] ms_div;
    reg ms_tick;
    reg [11:0] silence_ms;
    reg [11:0] win_ms;
    reg [2:0] sq_state;
    reg [1:0] sq_count;
    reg [6:0] unit_ms;
    reg [12:0] cto_units;
    reg [4:0] rx_state;
    reg rx_esc_pend;
    reg [15:0] rx_len;
    reg [15:0] rx_idx;
    reg [7:0] rx_sum;
    reg [7:0] last_type;
    reg tx_pend;
    reg [7:0] tx_pend_data;
    reg wr_fire;
    reg [7:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    reg next_tx_out_valid;
    reg next_tx_pend;

    wire aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid && !wr_fire;
    wire ar_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire escaped_mode = (active_mode == `HSFI_MODE_ESCAPED);
    wire cmd_write = wr_fire && (wr_addr == `HSFI_REG_CMD);
    wire cmd_exit = cmd_write && cmd_mode && (wr_data[7:0] == `HSFI_CMD_EXIT);
    wire cmd_apply = cmd_write && cmd_mode && (wr_data[7:0] == `HSFI_CMD_APPLY);
    wire cmd_known = cmd_write && cmd_mode && (wr_data[7:0] >= `HSFI_CMD_EXIT) && (wr_data[7:0] <= `HSFI_CMD_OTHER);
    // escaped mode is refused on SPI, so it falls back to plain framing
    wire [1:0] mode_eff = (framing_mode_select == `HSFI_MODE_ESCAPED && link_is_spi) ? `HSFI_MODE_FRAME :
        framing_mode_select;
    wire esc_hit = rx_valid && (rx_data == escape_sequence_char);
    wire cto_expire = (cto_units >= cmd_mode_timeout);

    // byte merge honouring write strobes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    function needs_esc;
        input [7:0] b;
        begin
            needs_esc = (b == `HSFI_DELIM) || (b == `HSFI_ESCB) || (b == `HSFI_XON) || (b == `HSFI_XOFF);
        end
    endfunction

    // byte seen after removing escapes; raw delimiter is flagged separately
    // receive unescape
    wire rx_is_esc = escaped_mode && !rx_esc_pend && (rx_data == `HSFI_ESCB);
    wire rx_raw_delim = !rx_esc_pend && (rx_data == `HSFI_DELIM);
    wire [7:0] rx_byte = rx_esc_pend ? (rx_data ^ `HSFI_ESC_XOR) : rx_data;
    wire rx_use = rx_valid && !rx_is_esc && !cmd_mode;

    // write address and data are taken together, answered one cycle later
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            wr_fire <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            s_axi_awready <= aw_take;
            s_axi_wready <= aw_take;
            wr_fire <= aw_take;
            if (aw_take) begin
                wr_addr <= s_axi_awaddr;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr[1:0] != 2'b00 || wr_addr > `HSFI_REG_STATUS ||
                    wr_addr == `HSFI_REG_DEVID || wr_addr == `HSFI_REG_STATUS) ? 2'b10 : 2'b00;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read path; unmapped reads give zero with slave error
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `HSFI_REG_MODE: s_axi_rdata <= {30'h00000000, framing_mode_select};
                    `HSFI_REG_ESC: s_axi_rdata <= {24'h000000, escape_sequence_char};
                    `HSFI_REG_GUARD: s_axi_rdata <= {20'h00000, guard_silence_time};
                    `HSFI_REG_CTO: s_axi_rdata <= {19'h00000, cmd_mode_timeout};
                    `HSFI_REG_ACKF: s_axi_rdata <= {16'h0000, ack_fail_count};
                    `HSFI_REG_DEVID: s_axi_rdata <= {4'h0, DEVICE_TYPE};
                    `HSFI_REG_CMD: s_axi_rdata <= 32'h00000000;
                    `HSFI_REG_STATUS: s_axi_rdata <= {16'h0000, last_type, 4'h0, !rx_state[0], active_mode, cmd_mode};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // settings registers; only the framing mode waits for apply or exit; out-of-range guard and timeout values are clamped
    wire [31:0] m = merge(32'h00000000, wr_data, wr_strb);
    always @(posedge aclk) begin : cfg_regs
        if (!aresetn) begin
            framing_mode_select <= `HSFI_RST_MODE;
            escape_sequence_char <= `HSFI_RST_ESC;
            guard_silence_time <= `HSFI_RST_GUARD;
            cmd_mode_timeout <= `HSFI_RST_CTO;
        end else if (wr_fire) begin
            case (wr_addr)
                `HSFI_REG_MODE: begin
                    if (wr_strb[0] && wr_data[1:0] <= `HSFI_MODE_ESCAPED) begin
                        framing_mode_select <= wr_data[1:0];
                    end
                end
                `HSFI_REG_ESC: begin
                    if (wr_strb[0]) begin
                        escape_sequence_char <= wr_data[7:0];
                    end
                end
                `HSFI_REG_GUARD: begin
                    if (m[15:0] < {4'h0, `HSFI_GUARD_MIN}) begin
                        guard_silence_time <= `HSFI_GUARD_MIN;
                    end else if (m[15:0] > {4'h0, `HSFI_GUARD_MAX}) begin
                        guard_silence_time <= `HSFI_GUARD_MAX;
                    end else begin
                        guard_silence_time <= m[11:0];
                    end
                end
                `HSFI_REG_CTO: begin
                    if (m[15:0] < {3'h0, `HSFI_CTO_MIN}) begin
                        cmd_mode_timeout <= `HSFI_CTO_MIN;
                    end else if (m[15:0] > {3'h0, `HSFI_CTO_MAX}) begin
                        cmd_mode_timeout <= `HSFI_CTO_MAX;
                    end else begin
                        cmd_mode_timeout <= m[12:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // failure counter; a failure in the clearing cycle still counts
    always @(posedge aclk) begin
        if (!aresetn) begin
            ack_fail_count <= 16'h0000;
        end else if (ack_retry_exhausted) begin
            if (wr_fire && wr_addr == `HSFI_REG_ACKF && wr_data[15:0] == 16'h0000) begin
                ack_fail_count <= 16'h0001;
            end else if (ack_fail_count != 16'hFFFF) begin
                ack_fail_count <= ack_fail_count + 16'h0001;
            end
        end else if (wr_fire && wr_addr == `HSFI_REG_ACKF && wr_data[15:0] == 16'h0000) begin
            ack_fail_count <= 16'h0000;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ms_div <= 16'h0000;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_div == MS_CYCLES[15:0] - 16'h0001);
            ms_div <= (ms_div == MS_CYCLES[15:0] - 16'h0001) ? 16'h0000 : ms_div + 16'h0001;
        end
    end

    // silence is measured to tick resolution, so it may read up to 1 ms long
    always @(posedge aclk) begin
        if (!aresetn) begin
            silence_ms <= 12'h000;
            win_ms <= 12'h000;
            sq_state <= SQ_IDLE;
            sq_count <= 2'd0;
        end else begin
            if (rx_valid) begin
                silence_ms <= 12'h000;
            end else if (ms_tick && silence_ms != 12'hFFF) begin
                silence_ms <= silence_ms + 12'h001;
            end
            if (ms_tick && win_ms != 12'hFFF) begin
                win_ms <= win_ms + 12'h001;
            end
            case (sq_state)
                SQ_IDLE: begin
                    if (esc_hit && !cmd_mode && silence_ms >= guard_silence_time) begin
                        sq_state <= SQ_CHARS;
                        sq_count <= 2'd1;
                        win_ms <= 12'h000;
                    end
                end
                SQ_CHARS: begin
                    if (win_ms >= guard_silence_time) begin
                        sq_state <= SQ_IDLE;
                    end else if (esc_hit) begin
                        sq_count <= sq_count + 2'd1;
                        if (sq_count + 2'd1 == `HSFI_ESC_COUNT) begin
                            sq_state <= SQ_POST;
                        end
                    end else if (rx_valid) begin
                        sq_state <= SQ_IDLE;
                    end
                end
                SQ_POST: begin
                    if (rx_valid || silence_ms >= guard_silence_time) begin
                        sq_state <= SQ_IDLE;
                    end
                end
                default: sq_state <= SQ_IDLE;
            endcase
        end
    end

    // command mode, its timeout and the settings that take effect
    always @(posedge aclk) begin
        apply_pulse <= 1'b0;
        save_pulse <= 1'b0;
        if (!aresetn) begin
            cmd_mode <= 1'b0;
            active_mode <= `HSFI_RST_MODE;
            unit_ms <= 7'd0;
            cto_units <= 13'h0000;
        end else begin
            if (ms_tick) begin
                unit_ms <= (unit_ms == `HSFI_CTO_UNIT_MS - 7'd1) ? 7'd0 : unit_ms + 7'd1;
                if (unit_ms == `HSFI_CTO_UNIT_MS - 7'd1) begin
                    cto_units <= cto_units + 13'h0001;
                end
            end
            if (!cmd_mode) begin
                if (sq_state == SQ_POST && !rx_valid && silence_ms >= guard_silence_time) begin
                    cmd_mode <= 1'b1;
                    unit_ms <= 7'd0;
                    cto_units <= 13'h0000;
                end
            end else if (cmd_exit) begin
                cmd_mode <= 1'b0;
                active_mode <= mode_eff;
            end else if (cmd_known) begin
                unit_ms <= 7'd0;
                cto_units <= 13'h0000;
                if (cmd_apply) begin
                    active_mode <= mode_eff;
                    apply_pulse <= 1'b1;
                end
                save_pulse <= (wr_data[7:0] == `HSFI_CMD_SAVE);
            end else if (cto_expire) begin
                cmd_mode <= 1'b0;
            end
        end
    end

    // frame receiver; data streams out and is committed by good or bad
    always @(posedge aclk) begin
        pass_valid <= 1'b0;
        frm_valid <= 1'b0;
        frm_is_type <= 1'b0;
        frm_good <= 1'b0;
        frm_bad <= 1'b0;
        if (!aresetn) begin
            rx_state <= RX_START;
            rx_esc_pend <= 1'b0;
            rx_len <= 16'h0000;
            rx_idx <= 16'h0000;
            rx_sum <= 8'h00;
            last_type <= 8'h00;
            pass_data <= 8'h00;
            frm_data <= 8'h00;
        end else if (active_mode == `HSFI_MODE_TRANSP || cmd_mode) begin
            rx_state <= RX_START;
            rx_esc_pend <= 1'b0;
            if (rx_valid && !cmd_mode) begin
                pass_valid <= 1'b1;
                pass_data <= rx_data;
            end
        end else if (rx_valid) begin
            rx_esc_pend <= rx_is_esc;
            if (escaped_mode && rx_raw_delim) begin
                if (!rx_state[0]) begin
                    frm_bad <= 1'b1;
                end
                rx_state <= RX_LENHI;
                rx_sum <= 8'h00;
            end else if (rx_use) begin
                case (rx_state)
                    RX_START: begin
                        if (rx_byte == `HSFI_DELIM) begin
                            rx_state <= RX_LENHI;
                            rx_sum <= 8'h00;
                        end
                    end
                    RX_LENHI: begin
                        rx_len[15:8] <= rx_byte;
                        rx_state <= RX_LENLO;
                    end
                    RX_LENLO: begin
                        rx_len[7:0] <= rx_byte;
                        rx_idx <= 16'h0000;
                        rx_state <= ({rx_len[15:8], rx_byte} == 16'h0000) ? RX_CSUM : RX_DATA;
                    end
                    RX_DATA: begin
                        rx_sum <= rx_sum + rx_byte;
                        rx_idx <= rx_idx + 16'h0001;
                        frm_valid <= 1'b1;
                        frm_data <= rx_byte;
                        frm_is_type <= (rx_idx == 16'h0000);
                        if (rx_idx == 16'h0000) begin
                            last_type <= rx_byte;
                        end
                        if (rx_idx + 16'h0001 == rx_len) begin
                            rx_state <= RX_CSUM;
                        end
                    end
                    RX_CSUM: begin
                        frm_good <= (rx_sum + rx_byte == `HSFI_CSUM_OK);
                        frm_bad <= (rx_sum + rx_byte != `HSFI_CSUM_OK);
                        rx_state <= RX_START;
                    end
                    default: rx_state <= RX_START;
                endcase
            end
        end
    end

    // transmit escaper: next state decides ready, so ready stays a flop
    always @* begin
        next_tx_out_valid = tx_out_valid;
        next_tx_pend = tx_pend;
        if (tx_out_valid && tx_out_ready) begin
            next_tx_out_valid = tx_pend;
            next_tx_pend = 1'b0;
        end
        if (tx_in_valid && tx_in_ready) begin
            next_tx_out_valid = 1'b1;
            next_tx_pend = escaped_mode && !tx_in_start && needs_esc(tx_in_data);
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_out_valid <= 1'b0;
            tx_out_data <= 8'h00;
            tx_pend <= 1'b0;
            tx_pend_data <= 8'h00;
            tx_in_ready <= 1'b0;
        end else begin
            tx_out_valid <= next_tx_out_valid;
            tx_pend <= next_tx_pend;
            tx_in_ready <= !next_tx_out_valid && !next_tx_pend;
            if (tx_out_valid && tx_out_ready && tx_pend) begin
                tx_out_data <= tx_pend_data;
            end
            if (tx_in_valid && tx_in_ready) begin
                if (escaped_mode && !tx_in_start && needs_esc(tx_in_data)) begin
                    tx_out_data <= `HSFI_ESCB;
                    tx_pend_data <= tx_in_data ^ `HSFI_ESC_XOR;
                end else begin
                    tx_out_data <= tx_in_data;
                end
            end
        end
    end

endmodule
